// ==== src/dual_timer_pkg.sv ====
// Package for the cascadable dual 16-bit timer: register map, field positions,
// reset values and shared types. Assumes a byte-addressed plain register port.
package dual_timer_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, low 16 bits of the peripheral space)
	// ----------------------------------------------------------------
	localparam logic [15:0] TIMER_A_CONTROL_ADDR = 16'h8040;
	localparam logic [15:0] TIMER_A_COUNT_ADDR   = 16'h8050;
	localparam logic [15:0] TIMER_A_PERIOD_ADDR  = 16'h8060;
	localparam logic [15:0] TIMER_B_CONTROL_ADDR = 16'h8080;
	localparam logic [15:0] TIMER_B_COUNT_ADDR   = 16'h8090;
	localparam logic [15:0] TIMER_B_PERIOD_ADDR  = 16'h80a0;

	// Alias offsets within each register's 16-byte slot
	localparam logic [3:0] ALIAS_PLAIN = 4'h0;
	localparam logic [3:0] ALIAS_CLR   = 4'h4;
	localparam logic [3:0] ALIAS_SET   = 4'h8;
	localparam logic [3:0] ALIAS_INV   = 4'hc;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int ENABLE_BIT      = 15;
	localparam int STOP_IDLE_BIT   = 13;
	localparam int GATE_EN_BIT     = 7;
	localparam int PRESCALE_LSB    = 4;
	localparam int CASCADE_BIT     = 3;
	localparam int CLK_SRC_BIT     = 1;

	// Writable masks: cascade select only exists in timer A
	localparam logic [15:0] CTRL_A_MASK = 16'ha0fa;
	localparam logic [15:0] CTRL_B_MASK = 16'ha0f2;

	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;

	// Gate bit as a mask, for the external-clock read-back
	localparam logic [15:0] GATE_READ_MASK = 16'h0080;
	// Last count value before a 16-bit half rolls over
	localparam logic [15:0] COUNT_TOP      = 16'hffff;

	// Largest prescale ratio minus one (1:256)
	localparam logic [7:0] PRESCALE_MAX = 8'hff;

	// Bus access carried as one packed bundle
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	// Per-timer decoded settings
	typedef struct packed {
		logic       enable;
		logic       stop_idle;
		logic       gate_en;
		logic [2:0] prescale;
		logic       clk_src;
	} timer_cfg_s;

	// Alias write kinds
	typedef enum logic [1:0] {WR_PLAIN, WR_CLR, WR_SET, WR_INV} wr_kind_e;

	// Prescale field to terminal count of the divider
	function automatic logic [7:0] prescale_limit(input logic [2:0] sel);
		case (sel)
			3'h0: prescale_limit = 8'h00;
			3'h1: prescale_limit = 8'h01;
			3'h2: prescale_limit = 8'h03;
			3'h3: prescale_limit = 8'h07;
			3'h4: prescale_limit = 8'h0f;
			3'h5: prescale_limit = 8'h1f;
			3'h6: prescale_limit = 8'h3f;
			default: prescale_limit = PRESCALE_MAX;
		endcase
	endfunction

	// Apply a plain, clear, set or invert write to a stored value
	function automatic logic [15:0] alias_apply(input wr_kind_e k, input logic [15:0] old,
		input logic [15:0] wd);
		case (k)
			WR_CLR:  alias_apply = old & ~wd;
			WR_SET:  alias_apply = old | wd;
			WR_INV:  alias_apply = old ^ wd;
			default: alias_apply = wd;
		endcase
	endfunction

endpackage

// ==== src/timer_tick_gen.sv ====
// Prescaler and clock qualification for one timer.
// Assumes gate and external clock inputs are synchronous to mclk.
`timescale 1ns/100ps
module timer_tick_gen
	import dual_timer_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Settings
	input  wire timer_cfg_s cfg,
	input  wire logic       idle,
	// Sources
	input  wire logic       ext_clk,
	input  wire logic       gate_in,
	// Result
	output logic            tick,
	output logic            gate_fall
);

	logic [7:0] div_q;
	logic [7:0] div_d;
	logic       ext_q;
	logic       gate_q;
	logic       run;
	logic       src_ev;
	logic       gated;
	logic       wrap;

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	// Gate only applies with the internal clock
	assign gated     = cfg.gate_en & ~cfg.clk_src;
	assign run       = cfg.enable & ~(cfg.stop_idle & idle);
	// External clock counts on rising edges, internal on every mclk, or only while the gate is high when gated
	assign src_ev    = cfg.clk_src ? (ext_clk & ~ext_q) : (gated ? gate_in : 1'b1);
	assign wrap      = (div_q >= prescale_limit(cfg.prescale));
	assign tick      = run & src_ev & wrap;
	assign gate_fall = run & gated & gate_q & ~gate_in;
	assign div_d     = (!run) ? div_q : (!src_ev ? div_q : (wrap ? 8'h00 : div_q + 8'h01));

	// Divider and edge registers; divider clears when the timer is off
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_q  <= 8'h00;
			ext_q  <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			div_q  <= cfg.enable ? div_d : 8'h00;
			ext_q  <= ext_clk;
			gate_q <= gate_in;
		end
	end

endmodule // timer_tick_gen

// ==== src/timer_counter16.sv ====
// One 16-bit count register with clear and software load.
// Assumes tick and carry-in come from the owning top.
`timescale 1ns/100ps
module timer_counter16
	import dual_timer_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Count control
	input  wire logic        tick,
	input  wire logic        clear,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	// State
	output logic [15:0]      count
);

	logic [15:0] count_q;
	logic [15:0] count_d;

	// Load wins over counting so software sees its written value
	assign count_d = load ? load_val : (clear ? COUNT_RESET : (tick ? count_q + 16'h0001 : count_q));
	assign count   = count_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			count_q <= COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

endmodule // timer_counter16

// ==== src/dual_timer.sv ====
// Top of the cascadable dual 16-bit timer with register port.
// Assumes a plain synchronous register port, read data one cycle after the strobe.
`timescale 1ns/100ps

// Behaviour
// - Each timer runs alone as 16-bit timer: internal, gated or external clock.
// - Timers A and B combine into one 32-bit timer with same modes.
// - Cascade select bit 3 of timer A control; 32-bit settings from A.
// - In 32-bit mode the period interrupt comes from timer B.
// - Only timer B drives the converter event trigger.
// - Enable bit 15 starts the timer; clearing it stops it.
// - Stop-in-idle bit 13 halts the timer during idle; else it keeps counting.
// - Gate bit 7 enables gating on internal clock; external clock reads zero.
// - Prescale bits 6:4 divide by 1,2,4,8,16,32,64,256.
// - Cascade select bit exists only in timer A control.
// - In 32-bit mode timer B enable, gate, prescale, source bits are ignored.
// - Clear, set, invert aliases at offsets 4, 8, 12 of each register.
// - Bits 31:16 and unimplemented bits ignore writes and read zero.
// - Cascade one forms a 32-bit timer; zero gives two 16-bit timers.
// - Source bit 1 picks the external pin, else the internal clock.
module dual_timer
	import dual_timer_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// Device state and pins
	input  wire logic        idle,
	input  wire logic        timer_a_ext_clock_pin,
	input  wire logic        timer_b_ext_clock_pin,
	input  wire logic        gate_a_pin,
	input  wire logic        gate_b_pin,
	// Events
	output logic             timer_a_irq,
	output logic             timer_b_irq,
	output logic             adc_trigger
);

	bus_req_s    req;
	logic [15:0] ctrl_a_q, ctrl_b_q, per_a_q, per_b_q;
	logic [31:0] rdata_q;
	logic        irq_a_q, irq_b_q, trig_q;
	timer_cfg_s  cfg_a, cfg_b_raw, cfg_b;
	logic        cascade;
	logic        tick_a, tick_b, fall_a, fall_b;
	logic [15:0] cnt_a, cnt_b;
	wr_kind_e    wkind;
	logic [11:0] slot;
	logic        sel_ca, sel_cb, sel_na, sel_nb, sel_pa, sel_pb;
	logic        match_a, match_b, match_32;
	logic        wrap_a, wrap_b, inc_b, clr_a, clr_b;
	logic        ev_a, ev_b;
	logic [15:0] rd_word;

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Register slot is the address without its alias nibble
	assign slot   = req.addr[15:4];
	assign sel_ca = (slot == TIMER_A_CONTROL_ADDR[15:4]);
	assign sel_na = (slot == TIMER_A_COUNT_ADDR[15:4]);
	assign sel_pa = (slot == TIMER_A_PERIOD_ADDR[15:4]);
	assign sel_cb = (slot == TIMER_B_CONTROL_ADDR[15:4]);
	assign sel_nb = (slot == TIMER_B_COUNT_ADDR[15:4]);
	assign sel_pb = (slot == TIMER_B_PERIOD_ADDR[15:4]);
	assign wkind  = (req.addr[3:0] == ALIAS_CLR) ? WR_CLR :
	                (req.addr[3:0] == ALIAS_SET) ? WR_SET :
	                (req.addr[3:0] == ALIAS_INV) ? WR_INV : WR_PLAIN;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Control writes store only masked bits; periods keep all 16; high half is never kept
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_a_q <= CTRL_RESET;
			ctrl_b_q <= CTRL_RESET;
			per_a_q  <= PERIOD_RESET;
			per_b_q  <= PERIOD_RESET;
		end else if (req.wr) begin
			if (sel_ca)
				ctrl_a_q <= alias_apply(wkind, ctrl_a_q, req.wdata[15:0]) & CTRL_A_MASK;
			if (sel_cb)
				ctrl_b_q <= alias_apply(wkind, ctrl_b_q, req.wdata[15:0]) & CTRL_B_MASK;
			if (sel_pa)
				per_a_q <= alias_apply(wkind, per_a_q, req.wdata[15:0]);
			if (sel_pb)
				per_b_q <= alias_apply(wkind, per_b_q, req.wdata[15:0]);
		end
	end

	// ----------------------------------------------------------------
	// Decoded settings
	// ----------------------------------------------------------------
	assign cascade = ctrl_a_q[CASCADE_BIT];
	assign cfg_a = '{enable: ctrl_a_q[ENABLE_BIT], stop_idle: ctrl_a_q[STOP_IDLE_BIT],
	                 gate_en: ctrl_a_q[GATE_EN_BIT], prescale: ctrl_a_q[PRESCALE_LSB+:3],
	                 clk_src: ctrl_a_q[CLK_SRC_BIT]};
	assign cfg_b_raw = '{enable: ctrl_b_q[ENABLE_BIT], stop_idle: ctrl_b_q[STOP_IDLE_BIT],
	                     gate_en: ctrl_b_q[GATE_EN_BIT], prescale: ctrl_b_q[PRESCALE_LSB+:3],
	                     clk_src: ctrl_b_q[CLK_SRC_BIT]};
	// Timer B divider stays idle in 32-bit mode; A drives both halves
	assign cfg_b = cascade ? '0 : cfg_b_raw;

	// ----------------------------------------------------------------
	// Tick generation
	// ----------------------------------------------------------------
	timer_tick_gen u_tick_a (
		.mclk      (mclk),
		.nrst      (nrst),
		.cfg       (cfg_a),
		.idle      (idle),
		.ext_clk   (timer_a_ext_clock_pin),
		.gate_in   (gate_a_pin),
		.tick      (tick_a),
		.gate_fall (fall_a)
	);

	timer_tick_gen u_tick_b (
		.mclk      (mclk),
		.nrst      (nrst),
		.cfg       (cfg_b),
		.idle      (idle),
		.ext_clk   (timer_b_ext_clock_pin),
		.gate_in   (gate_b_pin),
		.tick      (tick_b),
		.gate_fall (fall_b)
	);

	// ----------------------------------------------------------------
	// Count and match
	// ----------------------------------------------------------------
	// In 32-bit mode B counts the carry out of A
	assign match_a  = (cnt_a == per_a_q);
	assign match_b  = (cnt_b == per_b_q);
	assign match_32 = match_a & match_b;
	assign wrap_a   = tick_a & (cascade ? match_32 : match_a);
	assign wrap_b   = cascade ? wrap_a : (tick_b & match_b);
	assign inc_b    = cascade ? (tick_a & (cnt_a == COUNT_TOP)) : tick_b;
	assign clr_a    = wrap_a;
	assign clr_b    = wrap_b;

	timer_counter16 u_cnt_a (
		.mclk     (mclk),
		.nrst     (nrst),
		.tick     (tick_a),
		.clear    (clr_a),
		.load     (req.wr & sel_na),
		.load_val (alias_apply(wkind, cnt_a, req.wdata[15:0])),
		.count    (cnt_a)
	);

	timer_counter16 u_cnt_b (
		.mclk     (mclk),
		.nrst     (nrst),
		.tick     (inc_b),
		.clear    (clr_b),
		.load     (req.wr & sel_nb),
		.load_val (alias_apply(wkind, cnt_b, req.wdata[15:0])),
		.count    (cnt_b)
	);

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	// Gated mode reports on gate fall instead of period match
	assign ev_a = cascade ? 1'b0 : ((cfg_a.gate_en & ~cfg_a.clk_src) ? fall_a : wrap_a);
	assign ev_b = cascade ? ((cfg_a.gate_en & ~cfg_a.clk_src) ? fall_a : wrap_a)
	                      : ((cfg_b.gate_en & ~cfg_b.clk_src) ? fall_b : wrap_b);

	// One-cycle event pulses; converter trigger follows timer B only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			trig_q  <= 1'b0;
		end else begin
			irq_a_q <= ev_a;
			irq_b_q <= ev_b;
			trig_q  <= wrap_b;
		end
	end

	assign timer_a_irq = irq_a_q;
	assign timer_b_irq = irq_b_q;
	assign adc_trigger = trig_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Gate bit reads zero while the external clock is selected
	assign rd_word = sel_ca ? (ctrl_a_q & ~(ctrl_a_q[CLK_SRC_BIT] ? GATE_READ_MASK : 16'h0000)) :
	                 sel_cb ? (ctrl_b_q & ~(ctrl_b_q[CLK_SRC_BIT] ? GATE_READ_MASK : 16'h0000)) :
	                 sel_na ? cnt_a : sel_nb ? cnt_b :
	                 sel_pa ? per_a_q : sel_pb ? per_b_q : 16'h0000;

	// Read data stand one cycle, zero otherwise; unmapped reads give zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= req.rd ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	assign rdata = rdata_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_read_high_zero: assert property (@(posedge mclk) disable iff (!nrst) rdata[31:16] == 16'h0000)
		else $error("Read data high half not zero");
	a_cascade_no_a_irq: assert property (@(posedge mclk) disable iff (!nrst)
		cascade |=> !timer_a_irq || !$past(cascade))
		else $error("Timer A irq in cascade mode");
	a_disabled_holds: assert property (@(posedge mclk) disable iff (!nrst)
		(!cfg_a.enable && !(req.wr && sel_na)) |=> cnt_a == $past(cnt_a))
		else $error("Timer A counted while disabled");
	a_idle_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(idle && cfg_a.stop_idle) |-> !tick_a)
		else $error("Timer A ticked in idle");
	a_wrap_clears: assert property (@(posedge mclk) disable iff (!nrst)
		(wrap_a && !(req.wr && sel_na)) |=> cnt_a == 16'h0000)
		else $error("Counter did not wrap to zero");
	a_wrap_irq: assert property (@(posedge mclk) disable iff (!nrst)
		(wrap_b && !cascade && !cfg_b.gate_en) |=> timer_b_irq)
		else $error("Period match gave no interrupt");
	a_trig_follows_b: assert property (@(posedge mclk) disable iff (!nrst)
		adc_trigger |-> $past(wrap_b))
		else $error("Trigger without timer B wrap");
	a_ctrl_b_no_casc: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl_b_q[CASCADE_BIT] == 1'b0)
		else $error("Timer B holds cascade bit");
	a_casc_carry: assert property (@(posedge mclk) disable iff (!nrst)
		(cascade && tick_a && cnt_a == 16'hffff && !wrap_a && !(req.wr && sel_nb))
		|=> cnt_b == $past(cnt_b) + 16'h0001)
		else $error("Cascade carry lost");
	a_casc_b_still: assert property (@(posedge mclk) disable iff (!nrst) cascade |-> !tick_b)
		else $error("Timer B ticked in cascade");

	// ----------------------------------------------------------------
	// Multi-step checks
	// ----------------------------------------------------------------
	// Separate timer A in gated accumulation, gate just fell
	sequence s_gate_a_fall;
		!cascade && cfg_a.gate_en && !cfg_a.clk_src && fall_a;
	endsequence

	// A divided tick, then a cycle in which the divider is still above 1:1
	sequence s_tick_a_divided;
		(tick_a && cfg_a.prescale != 3'h0) ##1 (cfg_a.prescale != 3'h0);
	endsequence

	// Full 32-bit period reached with no count write in the way
	sequence s_casc_wrap;
		cascade && wrap_a && !(req.wr && (sel_na || sel_nb));
	endsequence

	// Gated mode reports once the gate closes
	a_gate_fall_irq: assert property (@(posedge mclk) disable iff (!nrst)
		s_gate_a_fall |=> timer_a_irq)
		else $error("No event after gate fall");
	a_casc_gate_irq: assert property (@(posedge mclk) disable iff (!nrst)
		(cascade && cfg_a.gate_en && !cfg_a.clk_src && fall_a) |=> timer_b_irq)
		else $error("Cascaded gate event not on timer B");
	// A divider above 1:1 never gives two ticks in a row
	a_prescale_gap: assert property (@(posedge mclk) disable iff (!nrst)
		s_tick_a_divided |-> !tick_a)
		else $error("Prescaler ticked on consecutive cycles");
	// Both halves clear together and the event leaves through timer B
	a_casc_wrap_zero: assert property (@(posedge mclk) disable iff (!nrst)
		s_casc_wrap |=> cnt_a == COUNT_RESET && cnt_b == COUNT_RESET)
		else $error("Cascaded wrap left a half nonzero");
	a_casc_wrap_event: assert property (@(posedge mclk) disable iff (!nrst)
		s_casc_wrap ##0 (!cfg_a.gate_en || cfg_a.clk_src) |=> timer_b_irq && adc_trigger)
		else $error("Cascaded wrap gave no timer B event");
	a_trig_on_wrap: assert property (@(posedge mclk) disable iff (!nrst)
		wrap_b |=> adc_trigger)
		else $error("Timer B wrap gave no trigger");
	a_b_idle_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(idle && cfg_b.stop_idle) |-> !tick_b)
		else $error("Timer B ticked in idle");
	// With the pin source, a low pin can never produce a tick
	a_ext_low_still: assert property (@(posedge mclk) disable iff (!nrst)
		(cfg_a.clk_src && !timer_a_ext_clock_pin) |-> !tick_a)
		else $error("Timer A ticked without a pin edge");
	a_gate_read_zero: assert property (@(posedge mclk) disable iff (!nrst)
		(req.rd && sel_ca && ctrl_a_q[CLK_SRC_BIT]) |=> !rdata[GATE_EN_BIT])
		else $error("Gate bit read back with pin source");

endmodule // dual_timer

// ==== sim/dual_timer_test.sv ====
// Self-checking bench for the cascadable dual 16-bit timer.
// Assumes the dual_timer top and its package; the bench drives the register port and pins itself.
`timescale 1ns/100ps
module dual_timer_test
	import dual_timer_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and design instance
	// ----------------------------------------------------------------
	logic        mclk, nrst, wr, rd, idle;
	logic [15:0] addr;
	logic [31:0] wdata, rdata;
	logic        timer_a_ext_clock_pin, timer_b_ext_clock_pin, gate_a_pin, gate_b_pin;
	logic        timer_a_irq, timer_b_irq, adc_trigger;
	int          fails, tests_run, seed, cnt_a, cnt_adc;

	dual_timer DUT (
		.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.idle(idle), .timer_a_ext_clock_pin(timer_a_ext_clock_pin),
		.timer_b_ext_clock_pin(timer_b_ext_clock_pin), .gate_a_pin(gate_a_pin), .gate_b_pin(gate_b_pin),
		.timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq), .adc_trigger(adc_trigger)
	);

	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Event tallies, taken mid-cycle so the registered pulses have settled
	always @(negedge mclk) begin
		if (timer_a_irq === 1'b1) cnt_a++;
		if (adc_trigger === 1'b1) cnt_adc++;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so sample it mid-cycle there
	task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask

	// Cycles until the next event pulse of timer t, cut off at bound
	task automatic wait_pulse(input int t, input int bound, output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (((t != 0) ? timer_b_irq : timer_a_irq) !== 1'b1 && n < bound);
	endtask

	// r: 0 control, 1 count, 2 period
	function automatic logic [15:0] reg_addr(input int t, input int r);
		return ((t != 0) ? TIMER_B_CONTROL_ADDR : TIMER_A_CONTROL_ADDR) + 16'(r * 16);
	endfunction

	function automatic int div_of(input int p);
		return (p == 7) ? 256 : (1 << p);
	endfunction

	// k: 1 clear, 2 set, 3 invert
	function automatic logic [15:0] alias_exp(input int k, input logic [15:0] old, input logic [15:0] wd);
		return (k == 1) ? (old & ~wd) : (k == 2) ? (old | wd) : (old ^ wd);
	endfunction

	task automatic test_done();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 60000 cycles
	initial begin
		#(8 * 60000);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d, e;
		int          n, per, k;
		seed = 32'he5e1;
		fails = 0;
		tests_run = 0;
		nrst = 1'b0;
		{wr, rd, idle, addr, wdata} = '0;
		{timer_a_ext_clock_pin, timer_b_ext_clock_pin, gate_a_pin, gate_b_pin} = '0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		for (int t = 0; t < 2; t++) for (int r = 0; r < 3; r++) begin
			bus_rd(reg_addr(t, r), d);
			check(d, (r == 2) ? 32'h0000ffff : 32'h00000000, "reset value");
		end
		// Writable bits; gate reads zero beside the external source
		for (int t = 0; t < 2; t++) begin
			bus_wr(reg_addr(t, 0), 32'hffffffff);
			bus_rd(reg_addr(t, 0), d);
			check(d, (t != 0) ? 32'h0000a072 : 32'h0000a07a, "control mask");
			bus_wr(reg_addr(t, 0), 32'h00000080);
			bus_rd(reg_addr(t, 0), d);
			check(d, 32'h00000080, "gate with internal clock");
		end
		bus_wr(16'h8070, 32'h0000ffff);
		bus_rd(16'h8070, d);
		check(d, 32'h00000000, "unmapped read");
		$display("Done: register map");
		// Random plain write, then clear, set and invert aliases on counts and periods
		for (int i = 0; i < 8; i++) begin
			e = $random(seed);
			// Periods keep their top bit so they never reach a reserved value
			if (i >= 4) e[15] = 1'b1;
			bus_wr(reg_addr(i % 2, 1 + i / 4), e);
			e = {16'h0000, e[15:0]};
			for (int j = 1; j < 4; j++) begin
				d = $random(seed);
				if (i >= 4 && j != 2) d[15] = 1'b0;
				bus_wr(reg_addr(i % 2, 1 + i / 4) + 16'(j * 4), d);
				e = {16'h0000, alias_exp(j, e[15:0], d[15:0])};
			end
			bus_rd(reg_addr(i % 2, 1 + i / 4), d);
			check(d, e, "alias sequence");
		end
		$display("Done: aliases");
		// Every prescale code on both timers, with a random legal period
		for (int t = 0; t < 2; t++) begin
			for (int p = 0; p < 8; p++) begin
				per = 2 + ($unsigned($random(seed)) % 8);
				bus_wr(reg_addr(t, 0), 32'h0);
				bus_wr(reg_addr(t, 1), 32'h0);
				bus_wr(reg_addr(t, 2), per);
				cnt_adc = 0;
				bus_wr(reg_addr(t, 0), 32'h8000 | (p << 4));
				wait_pulse(t, 3000, n);
				wait_pulse(t, 3000, n);
				check(n, (per + 1) * div_of(p), "event interval");
				// The tally shares this negedge with the pulse; let it settle first
				@(posedge mclk);
				check(cnt_adc, 2 * t, "converter trigger count");
			end
			bus_wr(reg_addr(t, 0), 32'h0);
		end
		$display("Done: prescaler");
		// Enable cleared through the clear alias freezes the count
		bus_wr(TIMER_A_PERIOD_ADDR, 32'hffff);
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h8000);
		repeat (5) @(posedge mclk);
		bus_wr(TIMER_A_CONTROL_ADDR + 16'h4, 32'h8000);
		@(posedge mclk);
		bus_rd(TIMER_A_COUNT_ADDR, d);
		repeat (10) @(posedge mclk);
		bus_rd(TIMER_A_COUNT_ADDR, e);
		check(e, d, "count frozen when off");
		check({31'h0, d != 32'h0}, 32'h1, "count ran when on");
		// Idle with and without stop-in-idle
		bus_wr(TIMER_A_CONTROL_ADDR + 16'h8, 32'ha000);
		idle <= 1'b1;
		bus_rd(TIMER_A_COUNT_ADDR, d);
		repeat (10) @(posedge mclk);
		bus_rd(TIMER_A_COUNT_ADDR, e);
		check(e, d, "halted in idle");
		bus_wr(TIMER_A_CONTROL_ADDR + 16'h4, 32'h2000);
		bus_rd(TIMER_A_COUNT_ADDR, d);
		repeat (10) @(posedge mclk);
		bus_rd(TIMER_A_COUNT_ADDR, e);
		check({31'h0, e != d}, 32'h1, "runs in idle");
		idle <= 1'b0;
		$display("Done: enable and idle");
		// External pin edges, gate bit set but ignored with the pin source
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h0);
		bus_wr(TIMER_A_COUNT_ADDR, 32'h0);
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h8082);
		k = 3 + ($unsigned($random(seed)) % 8);
		repeat (k) begin
			@(posedge mclk);
			timer_a_ext_clock_pin <= 1'b1;
			repeat (2) @(posedge mclk);
			timer_a_ext_clock_pin <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		repeat (4) @(posedge mclk);
		bus_rd(TIMER_A_COUNT_ADDR, d);
		check(d, k, "external edges counted");
		// Gated accumulation: count while high, event on the falling edge
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h0);
		bus_wr(TIMER_A_COUNT_ADDR, 32'h0);
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h8080);
		@(posedge mclk);
		gate_a_pin <= 1'b1;
		repeat (20) @(posedge mclk);
		gate_a_pin <= 1'b0;
		wait_pulse(0, 8, n);
		check({31'h0, n < 8}, 32'h1, "event after gate fall");
		bus_rd(TIMER_A_COUNT_ADDR, d);
		check({31'h0, d >= 32'd18 && d <= 32'd22}, 32'h1, "gated count");
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h0);
		$display("Done: clock sources");
		// Cascade: low half near its carry, timer B settings deliberately odd
		bus_wr(TIMER_A_COUNT_ADDR, 32'hfff0);
		bus_wr(TIMER_B_COUNT_ADDR, 32'h0001);
		bus_wr(TIMER_A_PERIOD_ADDR, 32'h0040);
		bus_wr(TIMER_B_PERIOD_ADDR, 32'h0002);
		bus_wr(TIMER_B_CONTROL_ADDR, 32'h0072);
		cnt_a = 0;
		cnt_adc = 0;
		bus_wr(TIMER_A_CONTROL_ADDR, 32'h8008);
		repeat (30) @(posedge mclk);
		bus_rd(TIMER_B_COUNT_ADDR, d);
		check(d, 32'h2, "carry into high half");
		wait_pulse(1, 120, n);
		check({31'h0, n < 120}, 32'h1, "combined period event");
		bus_rd(TIMER_B_COUNT_ADDR, d);
		check(d, 32'h0, "combined wrap");
		check(cnt_a, 32'h0, "low timer silent");
		check(cnt_adc, 32'h1, "trigger from high timer");
		$display("Done: cascade");
		test_done();
	end

endmodule // dual_timer_test
